// >>> inc/lsme_defines.vh
// Constants for the load, store, multiple and exclusive execution unit.
`ifndef LSME_DEFINES_VH
`define LSME_DEFINES_VH
`define LSME_OP_SINGLE_LOAD   4'h0
`define LSME_OP_PAIR_LOAD     4'h1
`define LSME_OP_MULTI_LOAD    4'h2
`define LSME_OP_MULTI_STORE   4'h3
`define LSME_OP_PUSH          4'h4
`define LSME_OP_POP           4'h5
`define LSME_OP_EXCL_LOAD     4'h6
`define LSME_OP_EXCL_STORE    4'h7
`define LSME_OP_EXCL_CLEAR    4'h8
`define LSME_SIZE_BYTE        2'h0
`define LSME_SIZE_HALF        2'h1
`define LSME_SIZE_WORD        2'h2
`define LSME_REG_SP           4'hD
`define LSME_REG_LR           4'hE
`define LSME_REG_PC           4'hF
`define LSME_WORD_STEP        32'h00000004
`define LSME_STATUS_OK        32'h00000000
`define LSME_STATUS_FAIL      32'h00000001
`define LSME_ST_IDLE          2'h0
`define LSME_ST_ISSUE         2'h1
`define LSME_ST_WAIT          2'h2
`endif

// >>> src/lsme_excl_monitor.v
// Local exclusive monitor holding the address and size of the last exclusive load.
`timescale 1ns/1ps
`default_nettype none
`include "lsme_defines.vh"
module lsme_excl_monitor (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Arm from an exclusive load
  input  wire        arm,
  input  wire [31:0] arm_addr,
  input  wire [1:0]  arm_size,
  // Disarm from an exclusive store or clear
  input  wire        disarm,
  // Accesses by other agents
  input  wire        snoop_valid,
  input  wire [31:0] snoop_addr,
  // Query from an exclusive store
  input  wire [31:0] query_addr,
  input  wire [1:0]  query_size,
  output wire        query_ok
);
  reg        armed;
  reg [31:0] mon_addr;
  reg [1:0]  mon_size;

  // Word granularity keeps the compare cheap; a neighbouring byte hit fails safe.
  wire snoop_hit = snoop_valid && (snoop_addr[31:2] == mon_addr[31:2]);

  assign query_ok = armed && (query_addr == mon_addr) &&
                    (query_size == mon_size); // RQ16

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armed    <= 1'b0;
      mon_addr <= 32'h00000000;
      mon_size <= 2'h0;
    end else if (arm) begin
      armed    <= 1'b1; // RQ21
      mon_addr <= arm_addr;
      mon_size <= arm_size;
    end else if (disarm || snoop_hit) begin
      armed <= 1'b0; // RQ21 RQ20 RQ17
    end
  end
endmodule
`default_nettype wire

// >>> src/lsme_exec.v
// Execution unit for relative, multiple, stack and exclusive memory accesses.
// Overview of operation
// RQ1 - Relative single loads stay within 4095 bytes, pair loads within 1020.
// RQ2 - Only word loads may target stack pointer or counter; pair targets differ.
// RQ3 - A load into the counter branches to the value with bit 0 cleared.
// RQ4 - A conditional counter load must end its conditional_block.
// RQ5 - None of these operations change the condition flags.
// RQ6 - Multiple transfers default to increment_after addressing.
// RQ7 - Increment_after walks upward by four, lowest register at lowest address.
// RQ8 - Decrement_before walks downward by four, highest register at highest.
// RQ9 - Base not counter; list lacks stack pointer, and base under writeback.
// RQ10 - A multiple load or pop into the counter branches, bit 0 cleared.
// RQ11 - Push is decrement_before store, pop increment_after load, on stack.
// RQ12 - Push omits the counter; pop never holds counter and link_register.
// RQ13 - Every multiple or stack list names at least one register.
// RQ14 - Exclusive loads read a word, byte or halfword into data_reg.
// RQ15 - A performed exclusive store writes status 0, a refused one 1.
// RQ16 - Exclusive store must match address and size of last exclusive load.
// RQ17 - Status 0 means no other agent touched the location meanwhile.
// RQ18 - Software keeps exclusive load and store close together.
// RQ19 - Exclusive offsets are multiples of four up to 1020, status reg apart.
// RQ20 - After exclusive_clear the next exclusive store fails with status 1.
// RQ21 - The monitor records each exclusive load; any exclusive store clears it.
`timescale 1ns/1ps
`default_nettype none
`include "lsme_defines.vh"
module lsme_exec (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Instruction command
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_op,
  input  wire [3:0]  cmd_data_reg,
  input  wire [3:0]  cmd_second_data_reg,
  input  wire [3:0]  cmd_base_reg,
  input  wire [3:0]  cmd_status_reg,
  input  wire [15:0] cmd_reg_list,
  input  wire        cmd_decrement_before,
  input  wire        cmd_writeback,
  input  wire [1:0]  cmd_size,
  input  wire        cmd_signed,
  input  wire [31:0] cmd_offset,
  input  wire [31:0] cmd_pc,
  output reg         cmd_ready,
  output reg         cmd_done,
  // Branch from a counter load
  output reg         branch_valid,
  output reg  [31:0] branch_target,
  // Register file port
  input  wire        rf_wr_en,
  input  wire [3:0]  rf_wr_idx,
  input  wire [31:0] rf_wr_data,
  input  wire [3:0]  rf_rd_idx,
  output reg  [31:0] rf_rd_data,
  // Memory bus
  output reg         mem_req,
  output reg         mem_write,
  output reg  [31:0] mem_addr,
  output reg  [1:0]  mem_size,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // Accesses by other agents
  input  wire        snoop_valid,
  input  wire [31:0] snoop_addr
);
  reg [31:0] rf [0:15];
  reg [1:0]  state;
  reg [3:0]  op;
  reg [15:0] remaining;
  reg [3:0]  cur_reg;
  reg [3:0]  second_reg;
  reg [3:0]  base_idx;
  reg [3:0]  status_idx;
  reg [31:0] cur_addr;
  reg [1:0]  size;
  reg        sign;
  reg        dec;
  reg        wb;
  reg        first;
  integer    i;

  function [3:0] lowest_set;
    input [15:0] mask;
    integer k;
    begin
      lowest_set = 4'h0;
      for (k = 15; k >= 0; k = k - 1) begin
        if (mask[k]) begin
          lowest_set = k[3:0];
        end
      end
    end
  endfunction

  function [3:0] highest_set;
    input [15:0] mask;
    integer k;
    begin
      highest_set = 4'h0;
      for (k = 0; k < 16; k = k + 1) begin
        if (mask[k]) begin
          highest_set = k[3:0];
        end
      end
    end
  endfunction

  function [31:0] extend;
    input [31:0] d;
    input [1:0]  sz;
    input        sg;
    begin
      if (sz == `LSME_SIZE_BYTE) begin
        extend = {{24{sg & d[7]}}, d[7:0]};
      end else if (sz == `LSME_SIZE_HALF) begin
        extend = {{16{sg & d[15]}}, d[15:0]};
      end else begin
        extend = d;
      end
    end
  endfunction

  wire        is_multi = (op == `LSME_OP_MULTI_LOAD) ||
                         (op == `LSME_OP_MULTI_STORE) ||
                         (op == `LSME_OP_PUSH) || (op == `LSME_OP_POP);
  wire [31:0] load_val = extend(mem_rdata, size, sign);
  wire [15:0] next_mask = remaining & ~(16'h0001 << cur_reg);
  wire [31:0] xaddr = rf[cmd_base_reg] + cmd_offset;
  wire        idle_cmd = (state == `LSME_ST_IDLE) && cmd_valid;
  wire        xstore_cmd = idle_cmd && (cmd_op == `LSME_OP_EXCL_STORE);
  wire        xclear_cmd = idle_cmd && (cmd_op == `LSME_OP_EXCL_CLEAR);
  wire        xload_done = (state == `LSME_ST_WAIT) && mem_ack &&
                           (op == `LSME_OP_EXCL_LOAD);
  wire        xquery_ok;

  lsme_excl_monitor u_monitor (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .arm         (xload_done),
    .arm_addr    (cur_addr),
    .arm_size    (size),
    .disarm      (xstore_cmd | xclear_cmd),
    .snoop_valid (snoop_valid),
    .snoop_addr  (snoop_addr),
    .query_addr  (xaddr),
    .query_size  (cmd_size),
    .query_ok    (xquery_ok)
  );

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 16; i = i + 1) begin
        rf[i] <= 32'h00000000;
      end
      state         <= `LSME_ST_IDLE;
      op            <= 4'h0;
      remaining     <= 16'h0000;
      cur_reg       <= 4'h0;
      second_reg    <= 4'h0;
      base_idx      <= 4'h0;
      status_idx    <= 4'h0;
      cur_addr      <= 32'h00000000;
      size          <= 2'h0;
      sign          <= 1'b0;
      dec           <= 1'b0;
      wb            <= 1'b0;
      first         <= 1'b0;
      cmd_ready     <= 1'b0;
      cmd_done      <= 1'b0;
      branch_valid  <= 1'b0;
      branch_target <= 32'h00000000;
      rf_rd_data    <= 32'h00000000;
      mem_req       <= 1'b0;
      mem_write     <= 1'b0;
      mem_addr      <= 32'h00000000;
      mem_size      <= 2'h0;
      mem_wdata     <= 32'h00000000;
    end else begin
      // Flags live outside and no path here reaches them.
      cmd_done     <= 1'b0; // RQ5
      branch_valid <= 1'b0;
      rf_rd_data   <= rf[rf_rd_idx];
      cmd_ready    <= (state == `LSME_ST_IDLE) && !cmd_valid;
      // An outside write loses to the unit's own write to the same index.
      if (rf_wr_en) begin
        rf[rf_wr_idx] <= rf_wr_data;
      end
      case (state)
        `LSME_ST_IDLE: begin
          if (cmd_valid) begin
            op         <= cmd_op;
            size       <= cmd_size;
            sign       <= cmd_signed;
            cur_reg    <= cmd_data_reg;
            second_reg <= cmd_second_data_reg;
            status_idx <= cmd_status_reg;
            base_idx   <= cmd_base_reg;
            dec        <= cmd_decrement_before; // RQ6
            wb         <= cmd_writeback;
            first      <= 1'b1;
            remaining  <= cmd_reg_list;
            state      <= `LSME_ST_ISSUE;
            if (cmd_op == `LSME_OP_SINGLE_LOAD ||
                cmd_op == `LSME_OP_PAIR_LOAD) begin
              cur_addr <= cmd_pc + cmd_offset;
              if (cmd_op == `LSME_OP_PAIR_LOAD) begin
                size <= `LSME_SIZE_WORD;
              end
            end else if (cmd_op == `LSME_OP_MULTI_LOAD ||
                         cmd_op == `LSME_OP_MULTI_STORE) begin
              cur_addr <= rf[cmd_base_reg];
              size     <= `LSME_SIZE_WORD;
              cur_reg  <= cmd_decrement_before ?
                          highest_set(cmd_reg_list) :
                          lowest_set(cmd_reg_list); // RQ7 RQ8
            end else if (cmd_op == `LSME_OP_PUSH ||
                         cmd_op == `LSME_OP_POP) begin
              cur_addr <= rf[`LSME_REG_SP];
              size     <= `LSME_SIZE_WORD;
              base_idx <= `LSME_REG_SP; // RQ11
              wb       <= 1'b1;
              dec      <= (cmd_op == `LSME_OP_PUSH);
              cur_reg  <= (cmd_op == `LSME_OP_PUSH) ?
                          highest_set(cmd_reg_list) :
                          lowest_set(cmd_reg_list);
            end else if (cmd_op == `LSME_OP_EXCL_LOAD) begin
              cur_addr <= xaddr; // RQ14
            end else if (cmd_op == `LSME_OP_EXCL_STORE) begin
              cur_addr <= xaddr;
              if (!xquery_ok) begin
                // Refused store: no bus cycle at all, status 1 at once.
                rf[cmd_status_reg] <= `LSME_STATUS_FAIL; // RQ15 RQ20
                cmd_done           <= 1'b1;
                state              <= `LSME_ST_IDLE;
              end
            end else begin
              cmd_done <= 1'b1; // RQ20
              state    <= `LSME_ST_IDLE;
            end
          end
        end
        `LSME_ST_ISSUE: begin
          mem_req   <= 1'b1;
          mem_addr  <= cur_addr;
          mem_size  <= size;
          mem_wdata <= rf[cur_reg];
          mem_write <= (op == `LSME_OP_MULTI_STORE) ||
                       (op == `LSME_OP_PUSH) ||
                       (op == `LSME_OP_EXCL_STORE);
          state     <= `LSME_ST_WAIT;
        end
        `LSME_ST_WAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            if (!mem_write) begin
              if (cur_reg == `LSME_REG_PC) begin
                rf[`LSME_REG_PC] <= {load_val[31:1], 1'b0}; // RQ3 RQ10
                branch_target    <= {load_val[31:1], 1'b0};
                branch_valid     <= 1'b1;
              end else begin
                rf[cur_reg] <= load_val; // RQ14
              end
            end
            if (op == `LSME_OP_EXCL_STORE) begin
              rf[status_idx] <= `LSME_STATUS_OK; // RQ15
            end
            if (is_multi && next_mask != 16'h0000) begin
              remaining <= next_mask;
              cur_reg   <= dec ? highest_set(next_mask) :
                                 lowest_set(next_mask); // RQ7 RQ8
              cur_addr  <= dec ? cur_addr - `LSME_WORD_STEP :
                                 cur_addr + `LSME_WORD_STEP;
              state     <= `LSME_ST_ISSUE;
            end else if (op == `LSME_OP_PAIR_LOAD && first) begin
              first    <= 1'b0;
              cur_reg  <= second_reg;
              cur_addr <= cur_addr + `LSME_WORD_STEP;
              state    <= `LSME_ST_ISSUE;
            end else begin
              if (is_multi && wb) begin
                rf[base_idx] <= cur_addr; // RQ7 RQ8 RQ11
              end
              cmd_done <= 1'b1;
              state    <= `LSME_ST_IDLE;
            end
          end
        end
        default: begin
          state <= `LSME_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> test/lsme_exec_properties.sv
// Port-level checks for the memory execution unit.
`timescale 1ns/1ps
`default_nettype none
`include "lsme_defines.vh"
module lsme_exec_properties (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Command side
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_op,
  input wire logic        cmd_decrement_before,
  input wire logic [1:0]  cmd_size,
  input wire logic        cmd_done,
  input wire logic        branch_valid,
  input wire logic [31:0] branch_target,
  // Memory side
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0]  mem_size,
  input wire logic        mem_ack
);
  logic        busy;
  logic [3:0]  op;
  logic [1:0]  sz;
  logic        down;
  logic        have;
  logic [31:0] prev;
  wire take = cmd_valid && (!busy || cmd_done);
  wire multi = op >= `LSME_OP_MULTI_LOAD && op <= `LSME_OP_POP;
  wire store = op == `LSME_OP_MULTI_STORE || op == `LSME_OP_PUSH;
  // The unit is idle again in its done cycle, so a take may coincide with it.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      op <= 4'h0;
      sz <= 2'h0;
      down <= 1'b0;
      have <= 1'b0;
      prev <= 32'h0;
    end else if (take) begin
      busy <= 1'b1;
      op <= cmd_op;
      sz <= cmd_size;
      down <= cmd_op == `LSME_OP_PUSH || (cmd_decrement_before
              && cmd_op != `LSME_OP_POP);
      have <= 1'b0;
    end else begin
      if (cmd_done)
        busy <= 1'b0;
      if (mem_req && mem_ack) begin
        have <= 1'b1;
        prev <= mem_addr;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_BRANCH_EVEN: assert property (branch_valid |-> !branch_target[0])
    else $error("branch target has bit 0 set");
  AST_BRANCH_AT_DONE: assert property (branch_valid |-> cmd_done)
    else $error("branch outside completion");
  AST_REQ_HOLDS: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_write))
    else $error("request changed before answer");
  AST_REQ_ENDS: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request kept after answer");
  AST_STEP: assert property ($rose(mem_req) && busy && multi && have
    |-> mem_addr == (down ? prev - 32'h4 : prev + 32'h4))
    else $error("multiple transfer address step wrong");
  AST_MULTI_WORD: assert property (mem_req && busy && multi
    |-> mem_size == `LSME_SIZE_WORD && mem_write == store)
    else $error("multiple transfer size or direction wrong");
  AST_EXCL_LOAD: assert property (mem_req && busy
    && op == `LSME_OP_EXCL_LOAD |-> !mem_write && mem_size == sz)
    else $error("exclusive load access wrong");
  AST_CLEAR_FAST: assert property (take && cmd_op == `LSME_OP_EXCL_CLEAR
    |=> cmd_done && !mem_req)
    else $error("exclusive clear not done at once");
  AST_PUSH_WRITES: assert property (take && cmd_op == `LSME_OP_PUSH
    |=> !mem_req ##1 (mem_req && mem_write))
    else $error("push did not start a write");
endmodule
`default_nettype wire

// >>> test/lsme_mem_model.sv
// Behavioural memory that answers the unit's bus after a set wait.
`timescale 1ns/1ps
`default_nettype none
module lsme_mem_model (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Bus from the unit
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic            mem_ack,
  output logic [31:0]     mem_rdata,
  // Wait cycles before each answer
  input wire logic [3:0]  dly
);
  logic [31:0] mem [0:255];
  logic [3:0]  cnt;
  wire [31:0] word = mem[mem_addr[9:2]] >> {mem_addr[1:0], 3'h0};
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'h5A000000 + i;
  end
  // Idle read data toggles so that a stale sample never looks right.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt >= dly) begin
      mem_ack <= 1'b1;
      cnt <= 4'h0;
      mem_rdata <= word;
      if (mem_write)
        mem[mem_addr[9:2]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> test/lsme_exec_tb.sv
// Self-checking bench for the memory execution unit.
`timescale 1ns/1ps
`default_nettype none
module lsme_exec_tb;
  typedef struct packed {
    logic [3:0] op, rt, rn, r2;
    logic [15:0] lst;
    logic dec, wb;
    logic [1:0] sz;
    logic [31:0] off;
    logic [3:0] ci;
    logic [31:0] cv, bt;
  } lsme_row_t;
  logic core_clk = 0, rstn = 0, cmd_valid = 0, rf_wr_en = 0, snoop_valid = 0;
  logic cmd_dec = 0, cmd_wb = 0, cmd_done, branch_valid, mem_req, mem_write;
  logic mem_ack, bv, cmd_ready;
  logic [3:0] cmd_op = 0, cmd_rt = 0, cmd_rn = 0, cmd_r2 = 0;
  logic [3:0] rf_wr_idx = 0, rf_rd_idx = 0, dly = 0;
  logic [15:0] cmd_lst = 0;
  logic [1:0] cmd_sz = 0, mem_size;
  logic [31:0] cmd_off = 0, rf_wr_data = 0, snoop_addr = 0, bt;
  logic [31:0] branch_target, rf_rd_data, mem_addr, mem_wdata, mem_rdata;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // Lists are non-empty and legal, offsets in range, stores match loads.
  // Commands are unconditional and each exclusive pair sits close together.
  lsme_row_t rows[17] = '{
    '{0,0,0,0,0,0,0,2,8,0,32'h5A000042,0},
    '{0,15,0,0,0,0,0,2,4,0,32'h5A000042,32'h5A000040},
    '{1,2,0,7,0,0,0,2,16,7,32'h5A000045,0},
    '{2,0,8,0,16'h0205,0,1,2,0,8,32'h48,0},
    '{3,0,1,0,16'h0078,1,1,2,0,1,32'h2F4,0},
    '{2,0,1,0,16'h0680,0,0,2,0,10,32'h05050505,0},
    '{4,0,0,0,16'h4001,0,0,2,0,13,32'h1FC,0},
    '{5,0,0,0,16'h8004,0,0,2,0,2,32'h5A000010,32'h122},
    '{6,4,8,0,0,0,0,2,0,4,32'h5A000012,0},
    '{7,6,8,5,0,0,0,2,0,5,0,0},
    '{6,4,8,0,0,0,0,2,0,4,32'h06060606,0},
    '{8,0,0,0,0,0,0,2,0,5,0,0},
    '{7,6,8,5,0,0,0,2,0,5,1,0},
    '{7,6,8,11,0,0,0,2,0,11,1,0},
    '{6,11,1,0,0,0,0,0,0,11,3,0},
    '{6,12,1,0,0,0,0,1,0,12,32'h0303,0},
    '{6,4,1,0,0,0,0,2,4,4,32'h04040404,0}};
  lsme_exec uut (.core_clk, .rstn, .cmd_valid, .cmd_op,
    .cmd_data_reg(cmd_rt), .cmd_second_data_reg(cmd_r2),
    .cmd_base_reg(cmd_rn), .cmd_status_reg(cmd_r2), .cmd_reg_list(cmd_lst),
    .cmd_decrement_before(cmd_dec), .cmd_writeback(cmd_wb),
    .cmd_size(cmd_sz), .cmd_signed(1'b0), .cmd_offset(cmd_off),
    .cmd_pc(32'h00000100), .cmd_ready, .cmd_done, .branch_valid,
    .branch_target, .rf_wr_en, .rf_wr_idx, .rf_wr_data, .rf_rd_idx,
    .rf_rd_data, .mem_req, .mem_write, .mem_addr, .mem_size, .mem_wdata,
    .mem_ack, .mem_rdata, .snoop_valid, .snoop_addr);
  lsme_mem_model mem (.core_clk, .rstn, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .dly);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(posedge core_clk);
    rf_wr_en <= 1'b1;
    rf_wr_idx <= i;
    rf_wr_data <= d;
    @(posedge core_clk);
    rf_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, input logic [31:0] exp);
    @(posedge core_clk);
    rf_rd_idx <= i;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(rf_rd_data, exp);
  endtask
  // Valid drops right after the take edge so the command is not re-taken.
  task automatic run(input lsme_row_t r);
    int k = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= r.op;
    cmd_rt <= r.rt;
    cmd_rn <= r.rn;
    cmd_r2 <= r.r2;
    cmd_lst <= r.lst;
    cmd_dec <= r.dec;
    cmd_wb <= r.wb;
    cmd_sz <= r.sz;
    cmd_off <= r.off;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    bv = 1'b0;
    do begin
      @(negedge core_clk);
      k++;
      if (branch_valid === 1'b1) begin
        bv = 1'b1;
        bt = branch_target;
      end
    end while (cmd_done !== 1'b1 && k < 100);
    // A command that never finishes counts against the run.
    if (cmd_done !== 1'b1) begin
      n_mismatch++;
    end
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    wr(8, 32'h40);
    wr(13, 32'h200);
    wr(14, 32'h123);
    wr(1, 32'h300);
    for (int i = 3; i < 7; i++)
      wr(i[3:0], 32'h01010101 * i);
    foreach (rows[j]) begin
      run(rows[j]);
      chk(bv ? bt : 32'h0, rows[j].bt);
      rd(rows[j].ci, rows[j].cv);
    end
    @(posedge core_clk);
    dly <= 4'h2;
    run('{6,4,8,0,0,0,0,2,0,0,0,0});
    @(posedge core_clk);
    snoop_valid <= 1'b1;
    snoop_addr <= 32'h4A;
    @(posedge core_clk);
    snoop_valid <= 1'b0;
    run('{7,7,8,5,0,0,0,2,0,0,0,0});
    rd(5, 32'h1);
    run('{6,4,8,0,0,0,0,2,0,0,0,0});
    rd(4, 32'h06060606);
    // A store that succeeds still disarms, so a second one must fail.
    run('{7,6,8,5,0,0,0,2,0,0,0,0});
    rd(5, 32'h0);
    run('{7,6,8,5,0,0,0,2,0,0,0,0});
    rd(5, 32'h1);
    @(posedge core_clk);
    rstn <= 1'b0;
    @(negedge core_clk);
    chk({29'h0, cmd_ready, cmd_done, mem_req}, 32'h0);
    @(posedge core_clk);
    rstn <= 1'b1;
    rd(8, 32'h0);
    run('{7,6,8,5,0,0,0,2,0,0,0,0});
    rd(5, 32'h1);
    chk({31'h0, cmd_ready}, 32'h1);
    tally_and_finish;
  end
endmodule
bind lsme_exec lsme_exec_properties u_props (.core_clk, .rstn, .cmd_valid,
  .cmd_op, .cmd_decrement_before, .cmd_size, .cmd_done, .branch_valid,
  .branch_target, .mem_req, .mem_write, .mem_addr, .mem_size, .mem_ack);
`default_nettype wire
